// >>> design/etdma_consts.svh
`ifndef ETDMA_CONSTS_SVH
`define ETDMA_CONSTS_SVH

// ----------------------------------------
// channel count and configuration memory
// ----------------------------------------
`define ETDMA_NCH 6
`define ETDMA_CFG_DEPTH 48

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ETDMA_GCTRL 12'h000
`define ETDMA_STATUS 12'h004
`define ETDMA_MASK 12'h008
`define ETDMA_FLAGS 12'h00C
// channel control words at 0x040 + 4*channel
`define ETDMA_CHCTRL_PAGE 7'h02
// config words at 0x100 + 0x20*channel + 4*word
`define ETDMA_CFG_PAGE 4'h1

// ----------------------------------------
// channel control fields
// ----------------------------------------
`define ETDMA_CC_EN 0
`define ETDMA_CC_TRIG 1
`define ETDMA_CC_IRQ_END 3
`define ETDMA_CC_OVR_EN 4
`define ETDMA_CC_CONT 5
`define ETDMA_TRIG_SEQ1 2'h1
`define ETDMA_TRIG_SEQ2 2'h2

// ----------------------------------------
// configuration word indices within a channel
// ----------------------------------------
`define ETDMA_W_BURST 3'h0
`define ETDMA_W_XFER 3'h1
`define ETDMA_W_SWRAP 3'h2
`define ETDMA_W_DWRAP 3'h3
`define ETDMA_W_SRC 3'h4
`define ETDMA_W_DST 3'h5
`define ETDMA_W_SBASE 3'h6
`define ETDMA_W_DBASE 3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define ETDMA_CHCTRL_RST 6'h00
`define ETDMA_FLAG_RST 12'h000
`define ETDMA_ADDR_RST 32'h0000_0000
`define ETDMA_CNT_RST 16'h0000

`endif

// >>> design/etdma_pkg.sv
package etdma_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FADDR = 3'b001,
      ST_FDATA = 3'b010,
      ST_BEGIN = 3'b011,
      ST_READ  = 3'b100,
      ST_WRITE = 3'b101,
      ST_POST  = 3'b110
   } etdma_state_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [15:0] wdata;
   } etdma_mreq_type;

   // config word: signed step above, size minus one below
   typedef struct packed {
      logic [15:0] step;
      logic [15:0] size;
   } etdma_pair_type;

endpackage

// >>> design/etdma_cfg_ram.sv
`timescale 1ns/1ps
`include "etdma_consts.svh"

module etdma_cfg_ram (
   input wire logic clk,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [5:0] raddr,
   output logic [31:0] rdata
);

   logic [31:0] mem [0:`ETDMA_CFG_DEPTH-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

// >>> design/etdma_engine.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "etdma_consts.svh"

// Operation
// - six channels, each with own trigger select
// - transfers start only on a peripheral trigger
// - channel one may take priority over others
// - either sequencer done event selectable per channel
// - every channel reaches converter results and memories
// - each trigger moves one burst, size minus one
// - sixteen bit burst count per transfer, minus one
// - one interrupt per transfer, start or end
// - signed word step added to both pointers
// - wrap replaces post-burst update after wrap count
// - independent source and destination wrap state
// - wrap adds step to base, copies base
// - wrap countdown reloads from size on wrap
// - shadows copied to active set at transfer start
// - trigger sets pending flag, burst start clears
// - trigger while pending is lost, flags overrun
// - misaligned result zero sync forces wrap resync
module etdma_engine
   import etdma_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SEQUENCER_ONE_DONE_EVENT,
   input wire logic SEQUENCER_TWO_DONE_EVENT,
   input wire logic RESULT_ZERO_SYNC,
   output etdma_mreq_type MEM_REQUEST,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_RDATA,
   output logic IRQ
);

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [15:0] s);
      step_addr = a + {{16{s[15]}}, s};
   endfunction

   function automatic logic [5:0] onehot(input logic [2:0] i);
      onehot = 6'h01 << i;
   endfunction

   function automatic logic trig_hit(input logic [5:0] cc, input logic s1, input logic s2);
      logic [1:0] sel;
      sel = cc[`ETDMA_CC_TRIG+1:`ETDMA_CC_TRIG];
      trig_hit = cc[`ETDMA_CC_EN] &
                 (((sel == `ETDMA_TRIG_SEQ1) & s1) | ((sel == `ETDMA_TRIG_SEQ2) & s2));
   endfunction

   // round robin after the last grant
   function automatic logic [3:0] pick_channel(input logic [5:0] req, input logic [2:0] last,
                                               input logic hi);
      integer k;
      integer t;
      pick_channel = 4'h0;
      for (k = 6; k >= 1; k--) begin
         t = last + k;
         if (t >= 6) begin
            t = t - 6;
         end
         if (req[t]) begin
            pick_channel = {1'b1, 3'(t)};
         end
      end
      if (hi && req[0]) begin
         pick_channel = 4'h8;
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   etdma_state_type state, next_state;
   logic [2:0] cur, last_grant, fidx;
   logic starting;
   etdma_pair_type burst_cfg, xfer_cfg, swrap_cfg, dwrap_cfg;
   logic [15:0] wleft, hold;
   logic hi_prio;
   logic [11:0] status, mask;
   logic [5:0] trigger_pending_flag, running, resync, aligned;
   logic [5:0] chctrl [0:5];
   logic [31:0] source_pointer [0:5];
   logic [31:0] destination_pointer [0:5];
   logic [31:0] source_wrap_base [0:5];
   logic [31:0] destination_wrap_base [0:5];
   logic [15:0] source_wrap_countdown [0:5];
   logic [15:0] destination_wrap_countdown [0:5];
   logic [15:0] bursts_left [0:5];

   logic src_we, dst_we, sbase_we, dbase_we, swc_we, dwc_we, bleft_we;
   logic [31:0] next_src, next_dst, next_sbase, next_dbase;
   logic [15:0] next_swc, next_dwc, next_bleft;
   logic run_set, run_clr, align_set, align_clr, last_word;
   logic [5:0] hit, ovr_set, grant_clr, sync_set, xfer_set, ovr_gate;
   logic [3:0] pick;
   logic [2:0] last_idx;

   logic acc, wr_en, is_cfg, is_gctrl, is_status, is_mask, is_flags, is_chctrl, mapped;
   logic cfg_rd, cfg_issued, mem_we;
   logic [5:0] apb_cfg_addr, mem_raddr;
   logic [31:0] mem_rdata, reg_rdata;

   // ----------------------------------------
   // register bus decode
   // ----------------------------------------
   assign acc = PSEL & PENABLE;
   assign is_cfg = (PADDR[11:8] == `ETDMA_CFG_PAGE) && (PADDR[7:5] < 3'h6);
   assign is_chctrl = (PADDR[11:5] == `ETDMA_CHCTRL_PAGE) && (PADDR[4:2] < 3'h6);
   assign is_gctrl = PADDR == `ETDMA_GCTRL;
   assign is_status = PADDR == `ETDMA_STATUS;
   assign is_mask = PADDR == `ETDMA_MASK;
   assign is_flags = PADDR == `ETDMA_FLAGS;
   assign mapped = is_cfg | is_chctrl | is_gctrl | is_status | is_mask | is_flags;
   assign cfg_rd = acc & ~PWRITE & is_cfg;
   // config reads wait for the registered memory output
   assign PREADY = ~cfg_rd | cfg_issued;
   assign PSLVERR = acc & PREADY & ~mapped;
   assign wr_en = acc & PWRITE & PREADY & mapped;
   assign mem_we = wr_en & is_cfg;
   assign apb_cfg_addr = is_cfg ? {PADDR[7:5], PADDR[4:2]} : 6'h00;
   // the engine owns the read port in its address cycle
   assign mem_raddr = (state == ST_FADDR) ? {cur, fidx} : apb_cfg_addr;
   assign PRDATA = reg_rdata;

   always_comb begin
      if (is_cfg) begin
         reg_rdata = mem_rdata;
      end else if (is_chctrl) begin
         reg_rdata = 32'(chctrl[PADDR[4:2]]);
      end else if (is_gctrl) begin
         reg_rdata = 32'(hi_prio);
      end else if (is_status) begin
         reg_rdata = 32'(status);
      end else if (is_mask) begin
         reg_rdata = 32'(mask);
      end else if (is_flags) begin
         reg_rdata = {13'h0000, state, 2'h0, running, 2'h0, trigger_pending_flag};
      end else begin
         reg_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_issued <= 1'b0;
      end else begin
         cfg_issued <= cfg_rd & ~cfg_issued & (state != ST_FADDR);
      end
   end

   etdma_cfg_ram u_cfg (
      .clk(SYS_CLK),
      .we(mem_we),
      .waddr(apb_cfg_addr),
      .wdata(PWDATA),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         hi_prio <= 1'b0;
         mask <= `ETDMA_FLAG_RST;
         for (int i = 0; i < `ETDMA_NCH; i++) begin
            chctrl[i] <= `ETDMA_CHCTRL_RST;
         end
      end else if (wr_en) begin
         if (is_gctrl) begin
            hi_prio <= PWDATA[0];
         end
         if (is_mask) begin
            mask <= PWDATA[11:0];
         end
         if (is_chctrl) begin
            chctrl[PADDR[4:2]] <= PWDATA[5:0];
         end
      end
   end

   // ----------------------------------------
   // triggers, pending, overrun, sync
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < `ETDMA_NCH; i++) begin
         hit[i] = trig_hit(chctrl[i], SEQUENCER_ONE_DONE_EVENT,
                           SEQUENCER_TWO_DONE_EVENT);
         sync_set[i] = RESULT_ZERO_SYNC & chctrl[i][`ETDMA_CC_CONT] &
                       running[i] & ~aligned[i];
         ovr_gate[i] = chctrl[i][`ETDMA_CC_OVR_EN];
      end
   end

   assign pick = pick_channel(trigger_pending_flag, last_grant, hi_prio);
   assign grant_clr = ((state == ST_IDLE) && pick[3]) ? onehot(pick[2:0]) : 6'h00;
   assign ovr_set = hit & trigger_pending_flag & ~grant_clr;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         trigger_pending_flag <= 6'h00;
         resync <= 6'h00;
      end else begin
         // a trigger in the clearing cycle stays pending
         trigger_pending_flag <= (trigger_pending_flag & ~grant_clr) | hit;
         resync <= (resync & ~((state == ST_BEGIN) ? onehot(cur) : 6'h00)) | sync_set;
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   assign xfer_set = ((state == ST_BEGIN) && starting &&
                      !chctrl[cur][`ETDMA_CC_IRQ_END]) ||
                     ((state == ST_POST) && (bursts_left[cur] == 16'h0000) &&
                      chctrl[cur][`ETDMA_CC_IRQ_END]) ? onehot(cur) : 6'h00;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         status <= `ETDMA_FLAG_RST;
      end else begin
         status <= (status & ~((wr_en && is_status) ? PWDATA[11:0] : 12'h000)) |
                   {ovr_set, xfer_set};
      end
   end

   assign IRQ = |(status & mask & {ovr_gate, 6'h3F});

   // ----------------------------------------
   // transfer engine
   // ----------------------------------------
   assign last_idx = starting ? `ETDMA_W_DBASE : `ETDMA_W_DWRAP;
   assign last_word = wleft == 16'h0000;

   always_comb begin
      next_state = state;
      src_we = 1'b0;
      dst_we = 1'b0;
      sbase_we = 1'b0;
      dbase_we = 1'b0;
      swc_we = 1'b0;
      dwc_we = 1'b0;
      bleft_we = 1'b0;
      next_src = source_pointer[cur];
      next_dst = destination_pointer[cur];
      next_sbase = source_wrap_base[cur];
      next_dbase = destination_wrap_base[cur];
      next_swc = source_wrap_countdown[cur];
      next_dwc = destination_wrap_countdown[cur];
      next_bleft = bursts_left[cur];
      run_set = 1'b0;
      run_clr = 1'b0;
      align_set = 1'b0;
      align_clr = 1'b0;
      case (state)
         ST_IDLE: begin
            if (pick[3]) begin
               next_state = ST_FADDR;
            end
         end
         ST_FADDR: begin
            next_state = ST_FDATA;
         end
         ST_FDATA: begin
            // shadows are fetched only when a transfer opens
            if (fidx == `ETDMA_W_SRC) begin
               src_we = 1'b1;
               next_src = mem_rdata;
            end
            if (fidx == `ETDMA_W_DST) begin
               dst_we = 1'b1;
               next_dst = mem_rdata;
            end
            if (fidx == `ETDMA_W_SBASE) begin
               sbase_we = 1'b1;
               next_sbase = mem_rdata;
            end
            if (fidx == `ETDMA_W_DBASE) begin
               dbase_we = 1'b1;
               next_dbase = mem_rdata;
            end
            next_state = (fidx == last_idx) ? ST_BEGIN : ST_FADDR;
         end
         ST_BEGIN: begin
            if (starting) begin
               run_set = 1'b1;
               align_set = 1'b1;
               bleft_we = 1'b1;
               next_bleft = xfer_cfg.size;
               swc_we = 1'b1;
               next_swc = swrap_cfg.size;
               dwc_we = 1'b1;
               next_dwc = dwrap_cfg.size;
            end else if (resync[cur]) begin
               // restart both pointers from the wrap bases
               align_set = 1'b1;
               src_we = 1'b1;
               next_src = source_wrap_base[cur];
               dst_we = 1'b1;
               next_dst = destination_wrap_base[cur];
               swc_we = 1'b1;
               next_swc = swrap_cfg.size;
               dwc_we = 1'b1;
               next_dwc = dwrap_cfg.size;
            end
            next_state = ST_READ;
         end
         ST_READ: begin
            if (MEM_ACK) begin
               next_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (MEM_ACK) begin
               src_we = 1'b1;
               next_src = step_addr(source_pointer[cur], burst_cfg.step);
               dst_we = 1'b1;
               next_dst = step_addr(destination_pointer[cur], burst_cfg.step);
               next_state = last_word ? ST_POST : ST_READ;
            end
         end
         ST_POST: begin
            next_state = ST_IDLE;
            if (bursts_left[cur] == 16'h0000) begin
               run_clr = 1'b1;
            end else begin
               bleft_we = 1'b1;
               next_bleft = bursts_left[cur] - 16'h0001;
               src_we = 1'b1;
               swc_we = 1'b1;
               if (source_wrap_countdown[cur] == 16'h0000) begin
                  align_set = 1'b1;
                  sbase_we = 1'b1;
                  next_sbase = step_addr(source_wrap_base[cur], swrap_cfg.step);
                  next_src = next_sbase;
                  next_swc = swrap_cfg.size;
               end else begin
                  align_clr = 1'b1;
                  next_src = step_addr(source_pointer[cur], xfer_cfg.step);
                  next_swc = source_wrap_countdown[cur] - 16'h0001;
               end
               dst_we = 1'b1;
               dwc_we = 1'b1;
               if (destination_wrap_countdown[cur] == 16'h0000) begin
                  dbase_we = 1'b1;
                  next_dbase = step_addr(destination_wrap_base[cur], dwrap_cfg.step);
                  next_dst = next_dbase;
                  next_dwc = dwrap_cfg.size;
               end else begin
                  next_dst = step_addr(destination_pointer[cur], xfer_cfg.step);
                  next_dwc = destination_wrap_countdown[cur] - 16'h0001;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state <= ST_IDLE;
         cur <= 3'h0;
         last_grant <= 3'h5;
         starting <= 1'b0;
         fidx <= 3'h0;
         wleft <= `ETDMA_CNT_RST;
         hold <= `ETDMA_CNT_RST;
      end else begin
         state <= next_state;
         if (state == ST_IDLE && pick[3]) begin
            cur <= pick[2:0];
            last_grant <= pick[2:0];
            starting <= ~running[pick[2:0]];
            fidx <= 3'h0;
         end
         if (state == ST_FDATA) begin
            fidx <= fidx + 3'h1;
         end
         if (state == ST_BEGIN) begin
            wleft <= burst_cfg.size;
         end
         if (state == ST_WRITE && MEM_ACK) begin
            wleft <= wleft - 16'h0001;
         end
         if (state == ST_READ && MEM_ACK) begin
            hold <= MEM_RDATA;
         end
      end
   end

   // step and size words are re-read every burst
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         burst_cfg <= '0;
         xfer_cfg <= '0;
         swrap_cfg <= '0;
         dwrap_cfg <= '0;
      end else if (state == ST_FDATA) begin
         if (fidx == `ETDMA_W_BURST) begin
            burst_cfg <= etdma_pair_type'(mem_rdata);
         end
         if (fidx == `ETDMA_W_XFER) begin
            xfer_cfg <= etdma_pair_type'(mem_rdata);
         end
         if (fidx == `ETDMA_W_SWRAP) begin
            swrap_cfg <= etdma_pair_type'(mem_rdata);
         end
         if (fidx == `ETDMA_W_DWRAP) begin
            dwrap_cfg <= etdma_pair_type'(mem_rdata);
         end
      end
   end

   // ----------------------------------------
   // per-channel active set
   // ----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         running <= 6'h00;
         aligned <= 6'h00;
         for (int i = 0; i < `ETDMA_NCH; i++) begin
            source_pointer[i] <= `ETDMA_ADDR_RST;
            destination_pointer[i] <= `ETDMA_ADDR_RST;
            source_wrap_base[i] <= `ETDMA_ADDR_RST;
            destination_wrap_base[i] <= `ETDMA_ADDR_RST;
            source_wrap_countdown[i] <= `ETDMA_CNT_RST;
            destination_wrap_countdown[i] <= `ETDMA_CNT_RST;
            bursts_left[i] <= `ETDMA_CNT_RST;
         end
      end else begin
         running <= (running | (run_set ? onehot(cur) : 6'h00)) &
                    ~(run_clr ? onehot(cur) : 6'h00);
         aligned <= (aligned | (align_set ? onehot(cur) : 6'h00)) &
                    ~(align_clr ? onehot(cur) : 6'h00);
         if (src_we) source_pointer[cur] <= next_src;
         if (dst_we) destination_pointer[cur] <= next_dst;
         if (sbase_we) source_wrap_base[cur] <= next_sbase;
         if (dbase_we) destination_wrap_base[cur] <= next_dbase;
         if (swc_we) source_wrap_countdown[cur] <= next_swc;
         if (dwc_we) destination_wrap_countdown[cur] <= next_dwc;
         if (bleft_we) bursts_left[cur] <= next_bleft;
      end
   end

   // ----------------------------------------
   // memory-side port, shared by all channels
   // ----------------------------------------
   always_comb begin
      MEM_REQUEST.valid = (state == ST_READ) || (state == ST_WRITE);
      MEM_REQUEST.write = state == ST_WRITE;
      MEM_REQUEST.addr = (state == ST_WRITE) ? destination_pointer[cur] : source_pointer[cur];
      MEM_REQUEST.wdata = hold;
   end

endmodule

// >>> test/etdma_engine_asserts.sv
`timescale 1ns/1ps
module etdma_engine_asserts
   import etdma_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [11:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic SEQUENCER_ONE_DONE_EVENT,
   input wire logic SEQUENCER_TWO_DONE_EVENT,
   input etdma_mreq_type MEM_REQUEST,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_RDATA
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   wire acc = PSEL & PENABLE;
   wire trig = SEQUENCER_ONE_DONE_EVENT | SEQUENCER_TWO_DONE_EVENT;
   logic [9:0] quiet;
   always_ff @(posedge SYS_CLK) begin
      quiet <= trig ? 10'h000 : (RST || quiet == 10'h3ff) ? 10'h3ff : quiet + 10'h001;
   end
   sequence s_rd_ack;
      MEM_REQUEST.valid && !MEM_REQUEST.write && MEM_ACK;
   endsequence
   sequence s_wr_req;
      MEM_REQUEST.valid && MEM_REQUEST.write;
   endsequence
   a_req_held: assert property (MEM_REQUEST.valid && !MEM_ACK |=> $stable(MEM_REQUEST))
      else $error("request changed before ack");
   a_read_then_write: assert property (s_rd_ack |=> s_wr_req)
      else $error("read not followed by write");
   a_data_moved: assert property (s_rd_ack |=> MEM_REQUEST.wdata == $past(MEM_RDATA))
      else $error("written word differs from read");
   a_word_starts_read: assert property ($rose(MEM_REQUEST.valid) |-> !MEM_REQUEST.write)
      else $error("word began with a write");
   a_start_on_trigger: assert property ($rose(MEM_REQUEST.valid) |-> quiet < 10'h3e8)
      else $error("traffic without a trigger");
   a_regs_no_wait: assert property (acc && PADDR[11:8] != 4'h1 |-> PREADY)
      else $error("register access stalled");
   a_ram_wait_bound: assert property (acc && !PREADY |-> ##[1:3] PREADY)
      else $error("config read too slow");
   a_err_in_access: assert property (PSLVERR |-> acc && PREADY)
      else $error("error outside access phase");
endmodule
bind etdma_engine etdma_engine_asserts i_etdma_engine_asserts (.SYS_CLK(SYS_CLK), .RST(RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SEQUENCER_ONE_DONE_EVENT(SEQUENCER_ONE_DONE_EVENT),
   .SEQUENCER_TWO_DONE_EVENT(SEQUENCER_TWO_DONE_EVENT), .MEM_REQUEST(MEM_REQUEST),
   .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));

// >>> test/etdma_mem_model.sv
`timescale 1ns/1ps
module etdma_mem_model
   import etdma_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input etdma_mreq_type req,
   output logic ack,
   output logic [15:0] rdata
);
   logic [7:0] lf;
   logic [15:0] last;
   // ----------------------------------------
   // memory with random wait states
   // ----------------------------------------
   // idle bus toggles so a stale capture is caught
   assign rdata = (ack && req.valid && !req.write) ? (req.addr[15:0] ^ 16'h0f0f) : ~last;
   always_ff @(posedge clk) begin
      lf <= rst ? 8'h5a : {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      ack <= !rst && req.valid && !ack && lf[0];
      last <= rdata;
   end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "etdma_consts.svh"
module testbench
   import etdma_pkg::*;
;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ev1 = 0, ev2 = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat, a_s, a_d, sb, db, sh[4];
   logic pready, pslverr, rerr, mem_ack, irq;
   logic [15:0] mem_rdata, seed = 16'h6f02, bsz, bst, tsz, tst, swsz, sws, dwsz, dws, sc, dc;
   logic [31:0] eq_a[$];
   logic [15:0] eq_d[$];
   etdma_mreq_type mem_request;
   int fail_count = 0, n_compared = 0;
   etdma_engine i_etdma_engine (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SEQUENCER_ONE_DONE_EVENT(ev1), .SEQUENCER_TWO_DONE_EVENT(ev2),
      .RESULT_ZERO_SYNC(1'b0), .MEM_REQUEST(mem_request), .MEM_ACK(mem_ack),
      .MEM_RDATA(mem_rdata), .IRQ(irq));
   etdma_mem_model i_etdma_mem_model (.clk(sys_clk), .rst(rst), .req(mem_request),
      .ack(mem_ack), .rdata(mem_rdata));
   initial forever #20 sys_clk = ~sys_clk;
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   function automatic logic [31:0] sx(input logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         wrap_up();
      end
      @(posedge sys_clk);
   endtask
   task automatic put_sh();
      for (int i = 0; i < 4; i++) begin
         sh[i] = {16'h0000, rnd()};
         apb(1'b1, 12'h110 + 12'(4 * i), sh[i]);
      end
   endtask
   task automatic burst(input bit last);
      for (int w = 0; w <= bsz; w++) begin
         eq_a.push_back(a_d);
         eq_d.push_back(a_s[15:0] ^ 16'h0f0f);
         a_s += sx(bst);
         a_d += sx(bst);
      end
      if (!last) begin
         if (sc == 0) begin
            sb += sx(sws);
            a_s = sb;
            sc = swsz;
         end else begin
            sc--;
            a_s += sx(tst);
         end
         if (dc == 0) begin
            db += sx(dws);
            a_d = db;
            dc = dwsz;
         end else begin
            dc--;
            a_d += sx(tst);
         end
      end
   endtask
   task automatic start_xfer();
      {a_s, a_d, sb, db} = {sh[0], sh[1], sh[2], sh[3]};
      {sc, dc} = {swsz, dwsz};
   endtask
   task automatic wait_idle();
      int n = 0;
      do begin
         apb(1'b0, `ETDMA_FLAGS);
         n++;
      end while ((rdat[18:16] !== 3'h0 || rdat[5:0] !== 6'h00) && n < 100);
      if (n >= 100) begin
         fail_count++;
         wrap_up();
      end
   endtask
   task automatic trig(input logic two);
      ev1 <= !two;
      ev2 <= two;
      @(posedge sys_clk);
      ev1 <= 1'b0;
      ev2 <= 1'b0;
   endtask
   always @(posedge sys_clk) begin
      if (mem_request.valid && mem_request.write && mem_ack) begin
         if (eq_a.size() == 0) begin
            chk("unexpected write", 32'h0000_0000, 32'h0000_0001);
         end else begin
            chk("dest address", eq_a.pop_front(), mem_request.addr);
            chk("moved word", 32'(eq_d.pop_front()), 32'(mem_request.wdata));
         end
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, `ETDMA_FLAGS);
      chk("flags at reset", 32'h0000_0000, rdat);
      apb(1'b0, 12'h020);
      chk("unmapped error", 32'h0000_0001, 32'(rerr));
      bsz = rnd() & 16'h0003;
      bst = {{13{seed[2]}}, seed[2:0]};
      tsz = 16'h0002;
      tst = rnd() & 16'h003f;
      swsz = rnd() & 16'h0001;
      sws = {{10{seed[9]}}, seed[5:0]};
      dwsz = 16'h0003;
      dws = 16'h0000;
      apb(1'b1, 12'h100, {bst, bsz});
      apb(1'b1, 12'h104, {tst, tsz});
      apb(1'b1, 12'h108, {sws, swsz});
      apb(1'b1, 12'h10c, {dws, dwsz});
      apb(1'b0, 12'h104);
      chk("config word", {tst, tsz}, rdat);
      put_sh();
      apb(1'b1, `ETDMA_GCTRL, 32'h0000_0001);
      apb(1'b1, `ETDMA_MASK, 32'h0000_0fff);
      // enable, seq one, irq at end, overrun irq
      apb(1'b1, 12'h040, 32'h0000_001b);
      for (int t = 0; t < 2; t++) begin
         start_xfer();
         for (int b = 0; b <= 2; b++) begin
            burst(b == 2);
            trig(t == 1);
            wait_idle();
            if (b == 0) begin
               apb(1'b0, `ETDMA_STATUS);
               chk("irq timing", 32'(t == 1), rdat);
               put_sh();
               trig(t == 0);
               wait_idle();
            end
         end
         apb(1'b0, `ETDMA_STATUS);
         chk("transfer flag", 32'h0000_0001, rdat);
         apb(1'b1, `ETDMA_MASK);
         chk("irq masked", 32'h0000_0000, 32'(irq));
         apb(1'b1, `ETDMA_MASK, 32'h0000_0fff);
         chk("irq on", 32'h0000_0001, 32'(irq));
         apb(1'b1, `ETDMA_STATUS, 32'h0000_0001);
         chk("irq cleared", 32'h0000_0000, 32'(irq));
         // enable, seq two, irq at start, overrun irq
         apb(1'b1, 12'h040, 32'h0000_0015);
      end
      start_xfer();
      burst(1'b0);
      burst(1'b0);
      ev2 <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ev2 <= 1'b0;
      wait_idle();
      apb(1'b0, `ETDMA_STATUS);
      chk("overrun status", 32'h0000_0041, rdat);
      chk("overrun irq", 32'h0000_0001, 32'(irq));
      apb(1'b1, `ETDMA_STATUS, 32'h0000_0fff);
      chk("irq idle", 32'h0000_0000, 32'(irq));
      chk("words left", 32'h0000_0000, 32'(eq_a.size()));
      wrap_up();
   end
endmodule
